// ### include/vco_bank_pkg.sv
// constants for the oscillator sub-register bank
package vco_bank_pkg;
    localparam int          PAYLOAD_W        = 9;
    localparam int          FWD_W            = 17;
    localparam logic [7:0]  FWD_REG_OFFSET   = 8'h05;
    localparam int          ID_LSB           = 0;
    localparam int          ID_MSB           = 2;
    localparam int          ADDR_LSB         = 3;
    localparam int          ADDR_MSB         = 6;
    localparam int          DATA_LSB         = 7;
    localparam int          DATA_MSB         = 15;
    localparam logic [2:0]  OSC_SUBSYS_ID    = 3'h0;
    localparam logic [3:0]  TUNING_OFFSET    = 4'h0;
    localparam logic [3:0]  ENABLES_OFFSET   = 4'h1;
    localparam logic [3:0]  DIVIDER_OFFSET   = 4'h2;
    localparam logic [3:0]  CONFIG_OFFSET    = 4'h3;
    localparam logic [8:0]  TUNING_RESET     = 9'h020;
    localparam logic [8:0]  ENABLES_RESET    = 9'h1FF;
    localparam logic [8:0]  DIVIDER_RESET    = 9'h001;
    localparam logic [8:0]  CONFIG_RESET     = 9'h092;
    localparam int          CAL_BIT          = 0;
    localparam int          MASTER_BIT       = 0;
    localparam int          OSC_EN_BIT       = 1;
    localparam int          FBBUF_EN_BIT     = 2;
    localparam int          IO_EN_BIT        = 3;
    localparam int          STAGE_EN_BIT     = 5;
    localparam int          NEG_EN_BIT       = 2;
    localparam int          POS_EN_BIT       = 3;
    localparam int          RLOSS_BIT        = 5;
    localparam logic [5:0]  DIV_MAX          = 6'h3E;
    localparam logic [1:0]  MUTE_ON_ZERO_DIV = 2'h0;
    localparam logic [1:0]  MUTE_DURING_CAL  = 2'h1;
    localparam logic [1:0]  MUTE_ALWAYS      = 2'h3;
endpackage

// ### include/vco_fwd_if.sv
// carries a decoded sub-register write between the two modules
`timescale 1ns/1ps
`default_nettype none
interface vco_fwd_if;
    logic       writeStrobe;
    logic [3:0] subAddr;
    logic [8:0] payload;
    modport source (output writeStrobe, output subAddr, output payload);
    modport sink   (input writeStrobe, input subAddr, input payload);
endinterface
`default_nettype wire

// ### design/vco_fwd_decode.sv
// decodes forwarding register writes into oscillator sub-register writes
`timescale 1ns/1ps
`default_nettype none
module vco_fwd_decode
(
    input  wire logic        mclk,      // clock
    input  wire logic        rst_n,     // async reset, active low
    input  wire logic        hostWrite, // one-cycle write pulse
    input  wire logic [7:0]  hostAddr,  // host register offset
    input  wire logic [16:0] hostData,  // host write data
    vco_fwd_if.source        fwd        // decoded write
);
    logic       next_writeStrobe;
    logic [3:0] next_subAddr;
    logic [8:0] next_payload;

    always_comb
    begin
        next_writeStrobe = hostWrite
            && hostAddr == vco_bank_pkg::FWD_REG_OFFSET
            && hostData[vco_bank_pkg::ID_MSB:vco_bank_pkg::ID_LSB]
               == vco_bank_pkg::OSC_SUBSYS_ID;
        next_subAddr = hostData[vco_bank_pkg::ADDR_MSB:
                                vco_bank_pkg::ADDR_LSB];
        next_payload = hostData[vco_bank_pkg::DATA_MSB:
                                vco_bank_pkg::DATA_LSB];
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fwd.writeStrobe <= 1'b0;
            fwd.subAddr     <= 4'h0;
            fwd.payload     <= 9'h000;
        end
        else
        begin
            fwd.writeStrobe <= next_writeStrobe;
            fwd.subAddr     <= next_subAddr;
            fwd.payload     <= next_payload;
        end
    end

    strobe_gate_a: assert property (@(posedge mclk) disable iff (!rst_n)
        fwd.writeStrobe |-> $past(hostAddr) == vco_bank_pkg::FWD_REG_OFFSET
            && $past(hostWrite))
        else $error("strobe without forwarding write");
    id_check_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (hostWrite && hostData[2:0] != 3'h0) |=> !fwd.writeStrobe)
        else $error("foreign subsystem forwarded");
endmodule
`default_nettype wire

// ### design/vco_indirect_register_bank.sv
// oscillator configuration bank reached through the forwarding register
`timescale 1ns/1ps
`default_nettype none
module vco_indirect_register_bank
(
    input  wire logic        mclk,          // clock, 25 MHz
    input  wire logic        rst_n,         // async reset, active low
    input  wire logic        hostWrite,     // host register write pulse
    input  wire logic [7:0]  hostAddr,      // host register offset
    input  wire logic [16:0] hostData,      // host write data
    input  wire logic        calActive,     // oscillator calibration running
    output logic             tuneToCal,     // tune from calibration voltage
    output logic [7:0]       subbandSelect, // oscillator subband
    output logic             oscEnable,     // oscillators running
    output logic             fbBufEnable,   // feedback divider buffer on
    output logic             outDivEnable,  // output divider on
    output logic             outStageEnable,// output stage on
    output logic [5:0]       divideRatio,   // effective output divide ratio
    output logic [1:0]       perfMode,      // performance mode
    output logic             rfNegEnable,   // negative RF pin driven
    output logic             rfPosEnable,   // positive RF pin driven
    output logic             returnLossSel, // 1 = better match
    output logic             rfMute         // RF outputs muted
);
    vco_fwd_if fwd ();

    vco_fwd_decode u_decode
    (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .hostWrite (hostWrite),
        .hostAddr  (hostAddr),
        .hostData  (hostData),
        .fwd       (fwd)
    );

    logic [8:0] tuning;
    logic [8:0] enables;
    logic [8:0] divider;
    logic [8:0] cfgReg;
    logic [8:0] next_tuning;
    logic [8:0] next_enables;
    logic [8:0] next_divider;
    logic [8:0] next_config;

    // odd ratios other than 1 drop to the even below, large ones clamp to the maximum
    function automatic logic [5:0] fold_ratio(input logic [5:0] raw);
        logic [5:0] r;
        r = raw;
        if (r > vco_bank_pkg::DIV_MAX)
            r = vco_bank_pkg::DIV_MAX;
        else if (r[0] && r != 6'h01)
            r = {r[5:1], 1'b0};
        return r;
    endfunction

    always_comb
    begin
        next_tuning  = tuning;
        next_enables = enables;
        next_divider = divider;
        next_config  = cfgReg;
        if (fwd.writeStrobe)
        begin
            case (fwd.subAddr)
                vco_bank_pkg::TUNING_OFFSET:  next_tuning  = fwd.payload;
                vco_bank_pkg::ENABLES_OFFSET: next_enables = fwd.payload;
                vco_bank_pkg::DIVIDER_OFFSET: next_divider = fwd.payload;
                vco_bank_pkg::CONFIG_OFFSET:  next_config  = fwd.payload;
                default:                      next_tuning  = tuning;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tuning  <= vco_bank_pkg::TUNING_RESET;
            enables <= vco_bank_pkg::ENABLES_RESET;
            divider <= vco_bank_pkg::DIVIDER_RESET;
            cfgReg  <= vco_bank_pkg::CONFIG_RESET;
        end
        else
        begin
            tuning  <= next_tuning;
            enables <= next_enables;
            divider <= next_divider;
            cfgReg  <= next_config;
        end
    end

    logic       next_tuneToCal;
    logic [7:0] next_subbandSelect;
    logic       next_oscEnable;
    logic       next_fbBufEnable;
    logic       next_outDivEnable;
    logic       next_outStageEnable;
    logic [5:0] next_divideRatio;
    logic [1:0] next_perfMode;
    logic       next_rfNegEnable;
    logic       next_rfPosEnable;
    logic       next_returnLossSel;
    logic       next_rfMute;
    logic       master;
    logic       ioOn;

    always_comb
    begin
        master = enables[vco_bank_pkg::MASTER_BIT];
        ioOn   = master && enables[vco_bank_pkg::IO_EN_BIT];
        next_tuneToCal      = tuning[vco_bank_pkg::CAL_BIT];
        next_subbandSelect  = tuning[8:1];
        next_oscEnable      = master
                              && enables[vco_bank_pkg::OSC_EN_BIT];
        next_fbBufEnable    = master
                              && enables[vco_bank_pkg::FBBUF_EN_BIT];
        next_outDivEnable   = ioOn;
        next_outStageEnable = ioOn
                              && enables[vco_bank_pkg::STAGE_EN_BIT];
        next_divideRatio    = fold_ratio(divider[5:0]);
        next_perfMode       = cfgReg[1:0];
        next_rfNegEnable    = cfgReg[vco_bank_pkg::NEG_EN_BIT];
        next_rfPosEnable    = cfgReg[vco_bank_pkg::POS_EN_BIT];
        next_returnLossSel  = cfgReg[vco_bank_pkg::RLOSS_BIT];
        case (cfgReg[8:7])
            vco_bank_pkg::MUTE_ON_ZERO_DIV:
                next_rfMute = divider[5:0] == 6'h00;
            vco_bank_pkg::MUTE_DURING_CAL:
                next_rfMute = calActive;
            vco_bank_pkg::MUTE_ALWAYS:
                next_rfMute = 1'b1;
            default:
                next_rfMute = 1'b0;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tuneToCal      <= 1'b0;
            subbandSelect  <= 8'h10;
            oscEnable      <= 1'b0;
            fbBufEnable    <= 1'b0;
            outDivEnable   <= 1'b0;
            outStageEnable <= 1'b0;
            divideRatio    <= 6'h01;
            perfMode       <= 2'h2;
            rfNegEnable    <= 1'b0;
            rfPosEnable    <= 1'b0;
            returnLossSel  <= 1'b0;
            rfMute         <= 1'b0;
        end
        else
        begin
            tuneToCal      <= next_tuneToCal;
            subbandSelect  <= next_subbandSelect;
            oscEnable      <= next_oscEnable;
            fbBufEnable    <= next_fbBufEnable;
            outDivEnable   <= next_outDivEnable;
            outStageEnable <= next_outStageEnable;
            divideRatio    <= next_divideRatio;
            perfMode       <= next_perfMode;
            rfNegEnable    <= next_rfNegEnable;
            rfPosEnable    <= next_rfPosEnable;
            returnLossSel  <= next_returnLossSel;
            rfMute         <= next_rfMute;
        end
    end

    update_addr_a: assert property (@(posedge mclk) disable iff (!rst_n)
        !(fwd.writeStrobe && fwd.subAddr == 4'h0) |=> $stable(tuning))
        else $error("tuning changed without its write");
    payload_store_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (fwd.writeStrobe && fwd.subAddr == 4'h2)
        |=> divider == $past(fwd.payload))
        else $error("divider payload not stored");
    master_off_a: assert property (@(posedge mclk) disable iff (!rst_n)
        !enables[0] |=> !oscEnable && !fbBufEnable && !outStageEnable
            && !outDivEnable)
        else $error("block on with master off");
    osc_indep_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (enables[0] && enables[1] && !enables[3]) |=> oscEnable)
        else $error("output enable stopped oscillator");
    div_even_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (divideRatio != 6'h01) |-> !divideRatio[0] && divideRatio <= 6'h3E)
        else $error("odd or oversized ratio");
    div_clamp_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (divider[5:0] == 6'h3F) |=> divideRatio == 6'h3E)
        else $error("ratio not clamped");
    zero_mute_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (cfgReg[8:7] == 2'h0) |=> rfMute == ($past(divider[5:0]) == 6'h00))
        else $error("zero divide mute wrong");
    mute_all_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (cfgReg[8:7] == 2'h3) |=> rfMute)
        else $error("unconditional mute missing");
    tune_cal_a: assert property (@(posedge mclk) disable iff (!rst_n)
        tuneToCal == $past(tuning[0]) && subbandSelect == $past(tuning[8:1]))
        else $error("tuning outputs wrong");
endmodule
`default_nettype wire

// ### test/vco_host_model.sv
// host model that writes the forwarding register
`timescale 1ns/1ps
`default_nettype none
module vco_host_model
(
    input  wire logic        mclk,      // clock
    output logic             hostWrite, // write pulse
    output logic [7:0]       hostAddr,  // register offset
    output logic [16:0]      hostData   // write data
);
    initial
    begin
        hostWrite = 1'b0;
        hostAddr  = 8'h00;
        hostData  = 17'h00000;
    end
    // drives one write and holds it over the next rising edge
    task automatic send(input logic [7:0] addr, input logic [2:0] id,
                        input logic [3:0] sub, input logic [8:0] pay);
        // unsupported mode codes and calibration registers are never sent
        if (!(addr == 8'h05 && id == 3'h0 && ((sub == 4'h3 &&
            (pay[0] == 1'b0 || pay[8:7] == 2'h2)) || sub inside {[4:6]})))
        begin
            hostWrite = 1'b1;
            hostAddr  = addr;
            hostData  = {1'b0, pay, sub, id};
            @(posedge mclk);
            #1;
        end
    endtask
    // a released bus drops the write pulse and shows the inverse of its last address and data
    task automatic idle();
        hostWrite = 1'b0;
        hostAddr  = ~hostAddr;
        hostData  = ~hostData;
    endtask
endmodule
`default_nettype wire

// ### test/tb_vco_indirect_register_bank.sv
// self-checking bench for the oscillator sub-register bank
`timescale 1ns/1ps
`default_nettype none
module tb_vco_indirect_register_bank;
    logic        mclk, rst_n, calActive, hostWrite;
    logic [7:0]  hostAddr;
    logic [16:0] hostData;
    logic        tuneToCal, oscEnable, fbBufEnable, outDivEnable;
    logic        outStageEnable, rfNegEnable, rfPosEnable;
    logic        returnLossSel, rfMute, muteExp;
    logic [7:0]  subbandSelect;
    logic [5:0]  divideRatio, divExp;
    logic [1:0]  perfMode;
    logic [8:0]  cfg [3];
    logic [8:0]  enPay [6];
    logic [3:0]  enExp [6];
    logic [8:0]  tunePay [2];
    int          n_mismatch;
    int          checked;

    vco_host_model u_host
    (
        .mclk, .hostWrite, .hostAddr, .hostData
    );
    vco_indirect_register_bank u_dut
    (
        .mclk, .rst_n, .hostWrite, .hostAddr, .hostData, .calActive,
        .tuneToCal, .subbandSelect, .oscEnable, .fbBufEnable,
        .outDivEnable, .outStageEnable, .divideRatio, .perfMode,
        .rfNegEnable, .rfPosEnable, .returnLossSel, .rfMute
    );

    initial
    begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    task automatic check(input string name, input logic [8:0] seen,
                         input logic [8:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask
    task automatic settle();
        u_host.idle();
        repeat (3) @(posedge mclk);
        #1;
    endtask
    task automatic put(input logic [3:0] sub, input logic [8:0] pay);
        u_host.send(8'h05, 3'h0, sub, pay);
        settle();
    endtask
    task automatic checkEn(input logic [3:0] exp);
        check("enables", {5'h00, oscEnable, fbBufEnable, outDivEnable,
              outStageEnable}, {5'h00, exp});
    endtask
    task automatic conclude();
        $display("mismatches %0d, comparisons %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial
    begin
        repeat (2000) @(posedge mclk);
        n_mismatch++;
        conclude();
    end

    initial
    begin
        n_mismatch = 0;
        checked = 0;
        calActive = 1'b0;
        rst_n = 1'b0;
        enPay = '{9'h1DF, 9'h1F7, 9'h1FD, 9'h1FB, 9'h1FE, 9'h1FF};
        enExp = '{4'hE, 4'hC, 4'h7, 4'hB, 4'h0, 4'hF};
        cfg = '{9'h039, 9'h197, 9'h0BF};
        tunePay = '{9'h14B, 9'h1FE};
        repeat (8) @(posedge mclk);
        #1 rst_n = 1'b1;
        @(posedge mclk);
        #1;
        check("subband", {1'b0, subbandSelect}, 9'h010);
        check("tuneToCal", {8'h00, tuneToCal}, 9'h000);
        checkEn(4'hF);
        check("divide", {3'h0, divideRatio}, 9'h001);
        check("perfMode", {7'h00, perfMode}, 9'h002);
        check("rfEn", {7'h00, rfNegEnable, rfPosEnable}, 9'h000);
        check("rloss", {8'h00, returnLossSel}, 9'h000);
        check("rfMute", {8'h00, rfMute}, 9'h000);
        for (int i = 0; i < 6; i++)
        begin
            put(4'h1, enPay[i]);
            checkEn(enExp[i]);
        end
        for (int i = 0; i < 2; i++)
        begin
            put(4'h0, tunePay[i]);
            check("tuneToCal", {8'h00, tuneToCal}, {8'h00, tunePay[i][0]});
            check("subband", {1'b0, subbandSelect}, {1'b0, tunePay[i][8:1]});
        end
        for (int v = 0; v < 64; v++)
        begin
            divExp = (v > 62) ? 6'h3E : (v < 2) ? 6'(v) : 6'(v & 62);
            put(4'h2, 9'(v));
            check("divide", {3'h0, divideRatio}, {3'h0, divExp});
            if (v == 0)
                check("rfMute", {8'h00, rfMute}, 9'h000);
        end
        put(4'h2, 9'h000);
        for (int k = 0; k < 3; k++)
        begin
            for (int c = 0; c < 2; c++)
            begin
                calActive = c[0];
                put(4'h3, cfg[k]);
                muteExp = (cfg[k][8:7] == 2'h1) ? calActive : 1'b1;
                check("perfMode", {7'h00, perfMode}, {7'h00, cfg[k][1:0]});
                check("rfEn", {7'h00, rfNegEnable, rfPosEnable},
                      {7'h00, cfg[k][2], cfg[k][3]});
                check("rloss", {8'h00, returnLossSel}, {8'h00, cfg[k][5]});
                check("rfMute", {8'h00, rfMute}, {8'h00, muteExp});
            end
        end
        put(4'h3, cfg[0]);
        put(4'h2, 9'h002);
        check("rfMute", {8'h00, rfMute}, 9'h000);
        u_host.send(8'h04, 3'h0, 4'h2, 9'h006);
        u_host.send(8'h05, 3'h1, 4'h2, 9'h006);
        u_host.send(8'h05, 3'h0, 4'h8, 9'h006);
        settle();
        check("divide", {3'h0, divideRatio}, 9'h002);
        check("subband", {1'b0, subbandSelect}, 9'h0FF);
        u_host.send(8'h05, 3'h0, 4'h0, 9'h020);
        u_host.send(8'h05, 3'h0, 4'h2, 9'h004);
        settle();
        check("subband", {1'b0, subbandSelect}, 9'h010);
        check("divide", {3'h0, divideRatio}, 9'h004);
        conclude();
    end
endmodule
`default_nettype wire
